// ==== design/switch_seq_pkg.sv ====
// Constants and types shared by the enable sequencer design.
package switch_seq_pkg;
  localparam int CLK_FREQ_HZ = 250000000;
  localparam int DEBOUNCE_TIME_MS = 5;
  localparam int DEBOUNCE_CYCLES = CLK_FREQ_HZ / 1000 * DEBOUNCE_TIME_MS;
  localparam int COUNT_W = 21;
  localparam int CHANNELS = 4;
  localparam logic [CHANNELS-1:0] ALL_ON = 4'hF;
  localparam logic [CHANNELS-1:0] ALL_OFF = 4'h0;
  typedef enum logic [1:0] {
    ST_OFF,
    ST_RELEASE,
    ST_ON,
    ST_OPEN
  } seq_state_t;
endpackage

// ==== design/debounce_counter.sv ====
// Counter that qualifies a continuous low request level.
`timescale 1ns/1ns
module debounce_counter
  import switch_seq_pkg::*;
#(
  parameter logic [COUNT_W-1:0] LIMIT = COUNT_W'(DEBOUNCE_CYCLES)
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic low_in,
  output logic done_out
);
  logic [COUNT_W-1:0] count;
  wire at_limit = (count == LIMIT);
  wire [COUNT_W-1:0] next_count =
    !low_in ? '0 : (at_limit ? count : count + COUNT_W'(1));

  // A high level clears the count so the next low starts afresh.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign done_out = at_limit && low_in;

  clear_on_high_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !low_in |=> count == '0)
    else $error("debounce count not cleared on high level");
endmodule

// ==== design/switch_enable_sequencer.sv ====
// Top level of the debounced load and signal switch enable sequencer.
`timescale 1ns/1ns
// Summary of operation
// - A qualified low request turns the load switch and paths on, high off.
// - The request must stay low for 5 ms of debounce count before enabling.
// - A high before the count ends clears it; the next low counts afresh.
// - While disabled all four card-side channel pull-downs are on.
// - On enabling the pull-downs release a cycle before the paths close.
// - While disabled the load switch output pull-down is on as well.
module switch_enable_sequencer
  import switch_seq_pkg::*;
#(
  parameter logic [COUNT_W-1:0] DEBOUNCE_LIMIT = COUNT_W'(DEBOUNCE_CYCLES)
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic switch_on_req_n_in,
  output logic load_switch_on_out,
  output logic load_discharge_on_out,
  output logic [CHANNELS-1:0] path_gate_on_out,
  output logic [CHANNELS-1:0] card_discharge_on_out
);
  logic req_meta;
  logic req_sync;
  logic debounced;
  seq_state_t state;
  seq_state_t next_state;
  logic gates;
  logic pulls;

  // Two-stage synchroniser for the asynchronous request pin.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_meta <= 1'b1;
      req_sync <= 1'b1;
    end else begin
      req_meta <= switch_on_req_n_in;
      req_sync <= req_meta;
    end
  end

  wire req_low = !req_sync;

  // The second stage must always take what the first held a cycle ago.
  sync_chain_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    req_sync == $past(req_meta))
    else $error("synchroniser stages out of step");

  debounce_counter #(
    .LIMIT(DEBOUNCE_LIMIT)
  ) u_debounce (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .low_in(req_low),
    .done_out(debounced)
  );

  // A finished count can only stand while the synchronised request is low.
  count_needs_low_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in) debounced |-> $past(req_low))
    else $error("debounce done without low request");

  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (debounced) begin
          next_state = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        next_state = req_low ? ST_ON : ST_OPEN;
      end
      ST_ON: begin
        if (!req_low) begin
          next_state = ST_OPEN;
        end
      end
      ST_OPEN: begin
        next_state = ST_OFF;
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // The state advances off, release, then on or open, and back to off.
  stay_off_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == ST_OFF && !debounced |=> state == ST_OFF)
    else $error("left off state without debounce");

  release_seen_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == ST_RELEASE |-> $past(debounced))
    else $error("release entered without count");

  release_brief_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == ST_RELEASE |=> state != ST_RELEASE)
    else $error("release state held too long");

  open_brief_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == ST_OPEN |=> state == ST_OFF)
    else $error("open state did not return to off");

  enter_off_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == ST_OFF |-> $past(state) == ST_OFF || $past(state) == ST_OPEN)
    else $error("off entered without opening first");

  leave_on_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == ST_ON && !req_low |=> state == ST_OPEN)
    else $error("on state not left on high request");

  stay_on_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == ST_ON && req_low |=> state == ST_ON)
    else $error("on state dropped while request low");

  // Gates close only in the on state; pulls are on only when idle.
  wire next_gates = (next_state == ST_ON);
  wire next_pulls = (next_state == ST_OFF);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gates <= 1'b0;
      pulls <= 1'b1;
    end else begin
      gates <= next_gates;
      pulls <= next_pulls;
    end
  end

  assign load_switch_on_out = gates;
  assign load_discharge_on_out = pulls;

  wire [CHANNELS-1:0] chan_gate_bits;
  wire [CHANNELS-1:0] chan_pull_bits;

  // Each channel keeps its own gate and pull-down flops, all fed by the
  // same decision, so the four channels always move on the same edge.
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : chan_slice
      logic chan_gate;
      logic chan_pull;
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          chan_gate <= 1'b0;
          chan_pull <= 1'b1;
        end else begin
          chan_gate <= next_gates;
          chan_pull <= next_pulls;
        end
      end
      assign chan_gate_bits[ch] = chan_gate;
      assign chan_pull_bits[ch] = chan_pull;

      chan_break_a: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) !(chan_gate && chan_pull))
        else $error("channel pull-down and path on together");

      chan_step_a: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        chan_gate == gates && chan_pull == pulls)
        else $error("channel out of step with load switch");
    end
  endgenerate

  assign path_gate_on_out = chan_gate_bits;
  assign card_discharge_on_out = chan_pull_bits;

  // The load switch and its pull-down keep the same order as the paths.
  never_both_on_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !(gates && pulls))
    else $error("pull-down and path on together");

  release_first_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(gates) |-> !$past(pulls) && !$past(gates))
    else $error("path closed before pull-down released");

  off_pulls_on_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == ST_OFF |-> card_discharge_on_out == ALL_ON
      && load_discharge_on_out)
    else $error("pull-downs not on while disabled");

  quick_off_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    gates && !req_low |=> !gates ##1 pulls)
    else $error("switches not opened promptly");

  pulls_return_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $fell(gates) |-> !pulls ##1 pulls)
    else $error("pull-downs not re-engaged after opening");

  enable_after_count_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    (state == ST_OFF && debounced) ##1 req_low |=> gates)
    else $error("enable did not follow debounce");

  no_early_on_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(gates) |-> $past(req_low, 2) && $past(req_low))
    else $error("enabled without low request");

  hold_off_high_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    gates |-> $past(req_low))
    else $error("switches closed after high request");

  on_outputs_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == ST_ON |-> load_switch_on_out && !load_discharge_on_out
      && path_gate_on_out == ALL_ON
      && card_discharge_on_out == ALL_OFF)
    else $error("outputs wrong while enabled");

  path_load_match_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    path_gate_on_out == (load_switch_on_out ? ALL_ON : ALL_OFF))
    else $error("paths and load switch disagree");

  pull_load_match_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    card_discharge_on_out == (load_discharge_on_out ? ALL_ON : ALL_OFF))
    else $error("card and load pull-downs disagree");

  load_break_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !(load_switch_on_out && load_discharge_on_out))
    else $error("load switch and its pull-down on together");
endmodule

// ==== verification/enable_switch_model.sv ====
// Enable contact model driving the pulled-up request pin.
`timescale 1ns/1ns
module enable_switch_model (
  input wire logic clk_in,
  input wire logic press_in,
  input wire logic bounce_in,
  output logic req_n_out
);
  logic chatter = 1'b0;
  always @(posedge clk_in) begin
    chatter <= ~chatter;
  end
  // A released contact leaves the pin to its pull-up.
  assign req_n_out = bounce_in ? chatter : ~press_in;
endmodule

// ==== verification/tb_switch_enable_sequencer.sv ====
// Self-checking bench for the debounced switch enable sequencer.
`timescale 1ns/1ns
module tb_switch_enable_sequencer;
  import switch_seq_pkg::*;
  localparam int LIM = 20;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic press = 1'b0;
  logic bounce = 1'b0;
  logic req_n, ld_on, ld_dis, gap;
  logic [CHANNELS-1:0] gate, pull;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;
  always #2 clk_in = ~clk_in;
  enable_switch_model u_sw (.clk_in(clk_in), .press_in(press),
    .bounce_in(bounce), .req_n_out(req_n));
  switch_enable_sequencer #(.DEBOUNCE_LIMIT(COUNT_W'(LIM))) u_dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .switch_on_req_n_in(req_n),
    .load_switch_on_out(ld_on), .load_discharge_on_out(ld_dis),
    .path_gate_on_out(gate), .card_discharge_on_out(pull));
  task automatic chk(input logic c, input string m);
    num_checks++;
    if (c !== 1'b1) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  function automatic logic is_off();
    return ld_on === 1'b0 && ld_dis === 1'b1 && gate === ALL_OFF &&
      pull === ALL_ON;
  endfunction
  task automatic tick();
    @(posedge clk_in);
    #1;
    chk((gate & pull) === ALL_OFF, "pull and path both on");
    chk((ld_on & ld_dis) === 1'b0, "load pull and switch on");
  endtask
  task automatic t_short();
    @(posedge clk_in) press <= 1'b1;
    repeat (LIM - 4) tick();
    @(posedge clk_in) press <= 1'b0;
    repeat (3) tick();
    @(posedge clk_in) press <= 1'b1;
    repeat (LIM - 4) tick();
    @(posedge clk_in) {press, bounce} <= 2'b01;
    repeat (3 * LIM) tick();
    chk(is_off(), "enabled without full count");
    @(posedge clk_in) bounce <= 1'b0;
    repeat (4) tick();
  endtask
  task automatic t_on();
    @(posedge clk_in) press <= 1'b1;
    n = 0;
    gap = 1'b0;
    while (ld_on !== 1'b1 && n < LIM + 20) begin
      tick();
      n++;
      gap |= pull === ALL_OFF && gate === ALL_OFF;
    end
    chk(n >= LIM && n <= LIM + 6, "enable delay wrong");
    chk(gap, "pull-downs not released first");
    repeat (5) tick();
    chk(gate === ALL_ON && pull === ALL_OFF, "not enabled");
    chk(ld_on === 1'b1 && ld_dis === 1'b0, "load not enabled");
  endtask
  task automatic t_off();
    @(posedge clk_in) press <= 1'b0;
    n = 0;
    gap = 1'b0;
    while (pull !== ALL_ON && n < 10) begin
      tick();
      n++;
      gap |= pull === ALL_OFF && gate === ALL_OFF;
    end
    chk(n <= 6 && gap, "disable slow or unordered");
    chk(is_off(), "not fully disabled");
  endtask
  task automatic t_cut();
    @(posedge clk_in) press <= 1'b1;
    repeat (LIM) tick();
    @(posedge clk_in) press <= 1'b0;
    gap = 1'b0;
    n = 0;
    repeat (8) begin
      tick();
      gap |= pull === ALL_OFF && gate === ALL_OFF;
      n += (ld_on === 1'b1);
    end
    chk(gap && n == 0, "cut release not handled");
    chk(is_off(), "not off after cut release");
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 1000) begin
      err_count++;
      test_done();
    end
  end
  initial begin
    repeat (4) @(posedge clk_in);
    chk(is_off(), "wrong outputs in reset");
    rst_n_in <= 1'b1;
    t_short();
    t_on();
    t_off();
    t_cut();
    t_on();
    t_off();
    test_done();
  end
endmodule
